// ---- common/srwd_pkg.sv ----
// Package with constants and types of the supervisor reset watchdog
package srwd_pkg;

    // Register bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register offsets
    localparam logic [11:0] OFS_RST_SET = 12'h000;
    localparam logic [11:0] OFS_WD_SET = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    // Setting widths and reset values
    localparam int SET_W = 16;
    localparam logic [15:0] RST_SET_DEF = 16'h05DC;
    localparam logic [15:0] WD_SET_DEF = 16'h05DC;

    // Status field positions
    localparam int ST_BIT_RESET = 0;
    localparam int ST_BIT_EXT = 1;
    localparam int ST_BIT_FLOAT = 2;
    localparam int ST_BIT_WDOFF = 3;
    localparam int ST_BIT_WDFLAG = 4;

    // Timing
    localparam real CLK_PERIOD_NS = 8.0;
    localparam real UNIT_TIME_US = 2.67;
    localparam int UNIT_CYC = int'($ceil(UNIT_TIME_US * 1000.0 / CLK_PERIOD_NS));
    localparam int PRE_W = 9;
    localparam logic [8:0] UNIT_LAST = 9'(UNIT_CYC - 1);
    localparam int WD_CNT_W = 25;
    localparam logic [24:0] EXT_MULT = 25'h00001F4;
    localparam logic [31:0] PULSE_PCT = 32'h0000005E;
    localparam logic [31:0] PCT_FULL = 32'h00000064;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_TIMEOUT,
        ST_RUN
    } srwd_fsm_type;

    // Asynchronous pins entering the clock domain
    typedef struct packed {
        logic below;
        logic mode;
        logic kick;
        logic floating;
    } srwd_pins_type;

    localparam srwd_pins_type PINS_RST = '{below: 1'b1, mode: 1'b0, kick: 1'b0, floating: 1'b0};

    typedef struct packed {
        srwd_fsm_type fsm;
        logic [8:0] rst_pre;
        logic [15:0] rst_cnt;
        logic [8:0] wd_pre;
        logic [24:0] wd_cnt;
        logic kick_d;
        logic mode_d;
        logic [15:0] rst_set;
        logic [15:0] wd_set;
        logic wd_flag;
        logic kick_o;
        logic rst_out;
        logic ready;
        logic err;
        logic [31:0] prdata;
    } srwd_state_type;

endpackage

// ---- verilog/srwd_sync.sv ----
// Two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
module srwd_sync (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire srwd_pkg::srwd_pins_type i_pins,
    output srwd_pkg::srwd_pins_type o_pins
);
    srwd_pkg::srwd_pins_type meta_r;
    srwd_pkg::srwd_pins_type sync_r;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= srwd_pkg::PINS_RST;
            sync_r <= srwd_pkg::PINS_RST;
        end else begin
            meta_r <= i_pins;
            sync_r <= meta_r;
        end
    end

    assign o_pins = sync_r;
endmodule

// ---- verilog/srwd_top.sv ----
// Supervisor: reset pulse generator and watchdog timer with APB registers
//
// How it works
// - Mode low normal, high multiplies timeout 500
// - Mode select change clears watchdog count
// - Every kick edge restarts watchdog from zero
// - Watchdog held cleared while reset asserted
// - Extended mode with floating kick disables watchdog
// - Zero watchdog setting disables watchdog expiry, floating extended kick pulses still repeat
// - Undervoltage drives reset low, held while low
// - Voltage recovery keeps reset one timeout more
// - Active-high reset output is the inverse
// - Reset timeout is setting times 2.67 us
// - Watchdog period is setting times 2.67 us
// - Floating extended kick freezes count: 94 percent pulse only if already reached, repeats at zero setting
`timescale 1ns/1ps
module srwd_top (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_below_threshold,
    input wire logic i_watchdog_mode_select,
    input wire logic i_watchdog_kick_input,
    input wire logic i_kick_floating,
    output logic o_watchdog_kick_out,
    output logic o_watchdog_kick_oe,
    output logic o_reset_n,
    output logic o_reset
);
    srwd_pkg::srwd_state_type st_r;
    srwd_pkg::srwd_state_type st_nxt;
    srwd_pkg::srwd_pins_type pins_raw;
    srwd_pkg::srwd_pins_type pins_s;

    logic kick_edge;
    logic mode_edge;
    logic ext_mode;
    logic float_off;
    logic wd_off;
    logic [24:0] wd_limit;
    logic [24:0] pulse_at;
    logic setup_ph;
    logic access_ok;
    logic hit;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic flag_clr;

    assign pins_raw = '{below: i_below_threshold, mode: i_watchdog_mode_select,
                        kick: i_watchdog_kick_input, floating: i_kick_floating};

    // Pins pass two flip-flops first
    srwd_sync u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_pins(pins_raw),
        .o_pins(pins_s)
    );

    always_comb begin
        st_nxt = st_r;
        // Edge detection on synchronised levels
        kick_edge = pins_s.kick ^ st_r.kick_d;
        mode_edge = pins_s.mode ^ st_r.mode_d;
        st_nxt.kick_d = pins_s.kick;
        st_nxt.mode_d = pins_s.mode;
        ext_mode = pins_s.mode;
        wd_limit = ext_mode ? 25'(st_r.wd_set * srwd_pkg::EXT_MULT) : 25'(st_r.wd_set);
        pulse_at = 25'((32'(wd_limit) * srwd_pkg::PULSE_PCT) / srwd_pkg::PCT_FULL);
        float_off = ext_mode && pins_s.floating;
        wd_off = (st_r.wd_set == 16'h0000) || float_off;
        st_nxt.kick_o = 1'b0;

        // Register bus
        setup_ph = i_psel && !i_penable;
        access_ok = i_psel && i_penable && st_r.ready;
        hit = (i_paddr == srwd_pkg::OFS_RST_SET) || (i_paddr == srwd_pkg::OFS_WD_SET) ||
              (i_paddr == srwd_pkg::OFS_STATUS);
        status_word = 32'h00000000;
        status_word[srwd_pkg::ST_BIT_RESET] = st_r.rst_out;
        status_word[srwd_pkg::ST_BIT_EXT] = ext_mode;
        status_word[srwd_pkg::ST_BIT_FLOAT] = pins_s.floating;
        status_word[srwd_pkg::ST_BIT_WDOFF] = wd_off;
        status_word[srwd_pkg::ST_BIT_WDFLAG] = st_r.wd_flag;
        unique case (i_paddr)
            srwd_pkg::OFS_RST_SET: rd_mux = {16'h0000, st_r.rst_set};
            srwd_pkg::OFS_WD_SET: rd_mux = {16'h0000, st_r.wd_set};
            srwd_pkg::OFS_STATUS: rd_mux = status_word;
            default: rd_mux = 32'h00000000;
        endcase
        st_nxt.ready = setup_ph;
        if (setup_ph) begin
            st_nxt.prdata = rd_mux;
            st_nxt.err = !hit;
        end
        flag_clr = 1'b0;
        if (access_ok && i_pwrite && !st_r.err) begin
            if (i_paddr == srwd_pkg::OFS_RST_SET) begin
                st_nxt.rst_set = i_pwdata[15:0];
            end
            if (i_paddr == srwd_pkg::OFS_WD_SET) begin
                st_nxt.wd_set = i_pwdata[15:0];
            end
            if (i_paddr == srwd_pkg::OFS_STATUS) begin
                flag_clr = i_pwdata[srwd_pkg::ST_BIT_WDFLAG];
            end
        end
        if (flag_clr) begin
            st_nxt.wd_flag = 1'b0;
        end

        // Reset and watchdog sequencing
        unique case (st_r.fsm)
            srwd_pkg::ST_HOLD: begin
                st_nxt.rst_pre = 9'h000;
                st_nxt.rst_cnt = 16'h0000;
                st_nxt.fsm = srwd_pkg::ST_TIMEOUT;
            end
            srwd_pkg::ST_TIMEOUT: begin
                if (st_r.rst_set == 16'h0000) begin
                    st_nxt.fsm = srwd_pkg::ST_RUN;
                end else if (st_r.rst_pre == srwd_pkg::UNIT_LAST) begin
                    st_nxt.rst_pre = 9'h000;
                    st_nxt.rst_cnt = st_r.rst_cnt + 16'h0001;
                    if (st_r.rst_cnt + 16'h0001 >= st_r.rst_set) begin
                        st_nxt.fsm = srwd_pkg::ST_RUN;
                    end
                end else begin
                    st_nxt.rst_pre = st_r.rst_pre + 9'h001;
                end
            end
            srwd_pkg::ST_RUN: begin
                if (kick_edge || mode_edge) begin
                    st_nxt.wd_pre = 9'h000;
                    st_nxt.wd_cnt = 25'h0000000;
                end else if (st_r.wd_pre == srwd_pkg::UNIT_LAST) begin
                    st_nxt.wd_pre = 9'h000;
                    if (float_off && (st_r.wd_cnt + 25'h0000001 >= pulse_at)) begin
                        st_nxt.kick_o = 1'b1;
                        st_nxt.wd_cnt = 25'h0000000;
                    end else if (!wd_off && (st_r.wd_cnt + 25'h0000001 >= wd_limit)) begin
                        st_nxt.fsm = srwd_pkg::ST_TIMEOUT;
                        st_nxt.rst_pre = 9'h000;
                        st_nxt.rst_cnt = 16'h0000;
                        st_nxt.wd_flag = 1'b1;
                    end else if (!wd_off) begin
                        st_nxt.wd_cnt = st_r.wd_cnt + 25'h0000001;
                    end
                end else begin
                    st_nxt.wd_pre = st_r.wd_pre + 9'h001;
                end
            end
        endcase
        if (pins_s.below) begin
            st_nxt.fsm = srwd_pkg::ST_HOLD;
        end
        if (st_nxt.fsm != srwd_pkg::ST_RUN) begin
            st_nxt.wd_pre = 9'h000;
            st_nxt.wd_cnt = 25'h0000000;
            st_nxt.kick_o = 1'b0;
        end
        st_nxt.rst_out = (st_nxt.fsm != srwd_pkg::ST_RUN);
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= '0;
            st_r.fsm <= srwd_pkg::ST_HOLD;
            st_r.rst_set <= srwd_pkg::RST_SET_DEF;
            st_r.wd_set <= srwd_pkg::WD_SET_DEF;
            st_r.rst_out <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_prdata = st_r.prdata;
    assign o_pready = st_r.ready;
    assign o_pslverr = st_r.ready && st_r.err;
    assign o_reset_n = !st_r.rst_out;
    assign o_reset = st_r.rst_out;
    assign o_watchdog_kick_out = st_r.kick_o;
    assign o_watchdog_kick_oe = float_off;

    // Helper counting cycles spent in the reset timeout
    logic [31:0] tmo_cyc_r;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tmo_cyc_r <= 32'h00000000;
        end else if (st_r.fsm == srwd_pkg::ST_TIMEOUT) begin
            tmo_cyc_r <= tmo_cyc_r + 32'h00000001;
        end else begin
            tmo_cyc_r <= 32'h00000000;
        end
    end

    // Helper counting watchdog cycles since last clear
    logic [31:0] wd_cyc_r;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wd_cyc_r <= 32'h00000000;
        end else if (st_nxt.wd_cnt == 25'h0000000 && st_nxt.wd_pre == 9'h000) begin
            wd_cyc_r <= 32'h00000000;
        end else begin
            wd_cyc_r <= wd_cyc_r + 32'h00000001;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_below_seen;
        pins_s.below;
    endsequence

    sequence s_reset_low_held;
        !o_reset_n [*2];
    endsequence

    sequence s_run_no_events;
        st_r.fsm == srwd_pkg::ST_RUN && !pins_s.below;
    endsequence

    a_below_reset_low: assert property (s_below_seen |=> s_reset_low_held or (!o_reset_n ##1 pins_s.below))
        else $error("reset not asserted during undervoltage");

    a_polarity_pair: assert property (o_reset == !o_reset_n)
        else $error("reset outputs not complementary");

    a_wd_held_reset: assert property (st_r.fsm != srwd_pkg::ST_RUN |-> st_r.wd_cnt == 25'h0000000 && st_r.wd_pre == 9'h000)
        else $error("watchdog counting while reset asserted");

    a_kick_restarts: assert property (s_run_no_events ##0 kick_edge |=> st_r.wd_cnt == 25'h0000000 && st_r.wd_pre == 9'h000)
        else $error("kick edge did not clear watchdog");

    a_mode_restarts: assert property (mode_edge |=> st_r.wd_cnt == 25'h0000000 && st_r.wd_pre == 9'h000)
        else $error("mode change did not clear watchdog");

    a_wd_off_zero: assert property (s_run_no_events ##0 st_r.wd_set == 16'h0000 |=> st_r.fsm == srwd_pkg::ST_RUN)
        else $error("disabled watchdog issued a reset");

    a_float_no_expire: assert property (s_run_no_events ##0 float_off |=> st_r.fsm == srwd_pkg::ST_RUN)
        else $error("floating kick in extended mode gave a reset");

    a_timeout_length: assert property ((st_r.fsm == srwd_pkg::ST_TIMEOUT && st_nxt.fsm == srwd_pkg::ST_RUN
        && st_r.rst_set != 16'h0000) |-> tmo_cyc_r + 32'h00000001 == 32'(st_r.rst_set) * 32'(srwd_pkg::UNIT_CYC))
        else $error("reset timeout length wrong");

    a_wd_expiry_time: assert property ((s_run_no_events ##0 st_nxt.fsm == srwd_pkg::ST_TIMEOUT) |->
        wd_cyc_r + 32'h00000001 == 32'(wd_limit) * 32'(srwd_pkg::UNIT_CYC))
        else $error("watchdog expired at wrong time");

    a_pulse_cause: assert property ($rose(o_watchdog_kick_out) |-> $past(float_off) && !st_r.rst_out)
        else $error("internal kick pulse without floating extended mode");

    a_pulse_single: assert property (o_watchdog_kick_out |=> !o_watchdog_kick_out)
        else $error("internal kick pulse longer than one cycle");

    a_expiry_flag: assert property ((s_run_no_events ##0 st_nxt.fsm == srwd_pkg::ST_TIMEOUT) |=>
        st_r.wd_flag && !o_reset_n)
        else $error("watchdog expiry did not assert reset");

endmodule

// ---- verif/srwd_cpu_model.sv ----
// Processor model driving the watchdog kick pin
`timescale 1ns/1ps
module srwd_cpu_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_run,
    input wire logic i_release,
    input wire logic i_kick_out,
    input wire logic i_kick_oe,
    output logic o_kick_pin,
    output logic o_floating
);
    logic drv = 1'b0;
    logic run_d = 1'b0;
    int cnt = 0;
    // Toggles every 501 cycles out of reset, one last toggle on stop
    always @(posedge i_clk) begin
        run_d <= i_run;
        cnt <= (i_run && i_reset_n && cnt < 500) ? cnt + 1 : 0;
        if ((i_run && i_reset_n && cnt == 500) || (run_d && !i_run)) begin
            drv <= ~drv;
        end
    end
    assign o_floating = i_release;
    // Released pin shows inverse of last value unless block drives it
    assign o_kick_pin = i_kick_oe ? i_kick_out : (i_release ? ~drv : drv);
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the supervisor reset watchdog
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, kout, koe, rst_n, rst_o, kick, flt;
    logic below = 1'b1;
    logic mode = 1'b0;
    logic run = 1'b0;
    logic rel = 1'b0;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    int bad;
    initial begin
        forever #4 clk = ~clk;
    end
    srwd_top i_srwd_top (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_below_threshold(below), .i_watchdog_mode_select(mode), .i_watchdog_kick_input(kick),
        .i_kick_floating(flt), .o_watchdog_kick_out(kout), .o_watchdog_kick_oe(koe), .o_reset_n(rst_n),
        .o_reset(rst_o));
    srwd_cpu_model i_srwd_cpu_model (.i_clk(clk), .i_reset_n(rst_n), .i_run(run), .i_release(rel),
        .i_kick_out(kout), .i_kick_oe(koe), .o_kick_pin(kick), .o_floating(flt));
    task end_sim;
        $display("Checks %0d, failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED at %0t: timeout", $time);
            end_sim;
        end
    end
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task chk_time(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %0d cycles, expected %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // One APB transfer, read data (reads only) and error compared on completion
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp, input logic err);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (!w) begin
            chk_val(prdata, exp);
        end
        chk_val({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // o_reset_n held at level v and o_reset at its inverse for c cycles
    task hold(input int c, input logic v);
        bad = 0;
        repeat (c) begin
            @(posedge clk);
            if (rst_n !== v || rst_o !== ~v) begin
                bad++;
            end
        end
        chk_time(bad, 0, 0);
    endtask
    task wait_rst(input logic v);
        n = 0;
        while (rst_n !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        hold(20, 1'b0);
        apb(1'b0, 12'h000, 32'h0, 32'h000005DC, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 32'h000005DC, 1'b0);
        apb(1'b1, 12'h000, 32'h00000002, 32'h0, 1'b0);
        apb(1'b1, 12'h004, 32'h00000003, 32'h0, 1'b0);
        apb(1'b0, 12'h000, 32'h0, 32'h00000002, 1'b0);
        apb(1'b1, 12'h008, 32'h0000000F, 32'h0, 1'b0);
        apb(1'b0, 12'h008, 32'h0, 32'h00000001, 1'b0);
        apb(1'b0, 12'h00C, 32'h0, 32'h00000000, 1'b1);
        apb(1'b1, 12'h00C, 32'h00000001, 32'h0, 1'b1);
        run <= 1'b1;
        below <= 1'b0;
        wait_rst(1'b1);
        chk_time(n, 668, 674);
        hold(4000, 1'b1);
        run <= 1'b0;
        wait_rst(1'b0);
        chk_time(n, 1002, 1010);
        wait_rst(1'b1);
        chk_time(n, 666, 672);
        wait_rst(1'b0);
        chk_time(n, 1000, 1006);
        apb(1'b0, 12'h008, 32'h0, 32'h00000011, 1'b0);
        apb(1'b1, 12'h008, 32'h00000010, 32'h0, 1'b0);
        apb(1'b0, 12'h008, 32'h0, 32'h00000001, 1'b0);
        wait_rst(1'b1);
        below <= 1'b1;
        wait_rst(1'b0);
        chk_time(n, 1, 4);
        hold(3000, 1'b0);
        below <= 1'b0;
        wait_rst(1'b1);
        chk_time(n, 668, 674);
        wait_rst(1'b0);
        chk_time(n, 1001, 1006);
        wait_rst(1'b1);
        hold(700, 1'b1);
        mode <= 1'b1;
        hold(700, 1'b1);
        mode <= 1'b0;
        hold(700, 1'b1);
        mode <= 1'b1;
        hold(1500, 1'b1);
        apb(1'b0, 12'h008, 32'h0, 32'h00000012, 1'b0);
        rel <= 1'b1;
        hold(10, 1'b1);
        chk_val({31'h0, koe}, 32'h00000001);
        chk_val({31'h0, kout}, 32'h00000000);
        apb(1'b0, 12'h008, 32'h0, 32'h0000001E, 1'b0);
        rel <= 1'b0;
        mode <= 1'b0;
        apb(1'b1, 12'h004, 32'h00000000, 32'h0, 1'b0);
        hold(2500, 1'b1);
        apb(1'b0, 12'h008, 32'h0, 32'h00000018, 1'b0);
        chk_val({31'h0, koe}, 32'h00000000);
        apb(1'b1, 12'h000, 32'h00000000, 32'h0, 1'b0);
        below <= 1'b1;
        wait_rst(1'b0);
        below <= 1'b0;
        wait_rst(1'b1);
        chk_time(n, 4, 6);
        end_sim;
    end
endmodule
